// file: design/dmace_pkg.sv
// Shared constants, register layout and carrier types of the DMA transfer engine
package dmace_pkg;

  // Number of channels served by one arbiter
  localparam int NCH = 7;

  // Register map, byte addresses on the APB
  localparam logic [7:0] OFF_STATUS = 8'h00;  // Flag and any-event status, read only
  localparam logic [7:0] OFF_CLEAR  = 8'h04;  // Flag clear, write one to clear
  localparam logic [7:0] OFF_CH0    = 8'h08;  // First channel block
  localparam logic [7:0] CH_STRIDE  = 8'h14;  // Spacing of channel blocks
  localparam logic [7:0] CH_SPAN    = 8'h10;  // Mapped bytes inside a block

  // Register select inside a channel block (bits 3:2 of the offset from the block base)
  localparam logic [1:0] SEL_CFG   = 2'h0;  // channel_config
  localparam logic [1:0] SEL_CNT   = 2'h1;  // xfer_count
  localparam logic [1:0] SEL_PADDR = 2'h2;  // periph_base_addr
  localparam logic [1:0] SEL_MADDR = 2'h3;  // mem_base_addr

  // Per-channel nibble in irq_status and in the clear register
  localparam int ST_W    = 4;
  localparam int ST_ANY  = 0;  // any_event_flag
  localparam int ST_DONE = 1;  // done_flag
  localparam int ST_HALF = 2;  // half_done_flag
  localparam int ST_ERR  = 3;  // error_flag

  // Item size codes
  localparam logic [1:0] SZ_8  = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;

  // Reset values
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // channel_config layout, bit 0 upward: enable, irq enables, mode, sizes, priority
  typedef struct packed {
    logic       mem_to_mem_sel;     // 14
    logic [1:0] channel_priority;   // 13:12, 3 is highest
    logic [1:0] mem_item_size;      // 11:10
    logic [1:0] periph_item_size;   // 9:8
    logic       mem_incr_en;        // 7
    logic       periph_incr_en;     // 6
    logic       circular_sel;       // 5
    logic       dir;                // 4, 1 reads memory side
    logic       error_irq_en;       // 3
    logic       half_done_irq_en;   // 2
    logic       done_irq_en;        // 1
    logic       en;                 // 0
  } dmace_cfg_t;

  localparam int         CFG_W   = $bits(dmace_cfg_t);
  localparam dmace_cfg_t CFG_RST = '0;

  // System bus request carried out of the engine
  typedef struct packed {
    logic        req;    // Held until bus_ready
    logic        we;     // 1 write, 0 read
    logic [1:0]  size;   // Item size code
    logic [31:0] addr;   // Byte address
    logic [31:0] wdata;  // Item in the low bits
  } dmace_bus_t;

  // Engine sequencer
  typedef enum logic [1:0] {
    FSM_IDLE,
    FSM_READ,
    FSM_WRITE
  } dmace_fsm_t;

endpackage

// file: design/dmace_engine.sv
// Multi-channel DMA transfer engine with APB registers and a system bus master
//
// Overview of operation
// - Request moves one item, then count decrements
// - First transfer uses base addresses, then pointers
// - Direction bit picks side; mem_to_mem_sel memory
// - Memory-to-memory starts on enable, no request
// - Memory-to-memory treats peripheral address as memory
// - Addresses, count, mode bits locked while enabled; mem_to_mem_sel, sizes and priority stay writable here
// - Circular reloads count and pointers at zero
// - Half flag when remaining below half initial
// - Done flag when count reaches zero
// - Bus error sets error flag, clears enable
// - Any-event flag per channel in status
// - Sixteen-bit count, up to 65535 items
// - Count writable when disabled, shows remaining
// - Increment bits advance pointers, else fixed
// - Size fields select 8, 16, 32 bits
// - Each side steps by its own size
// - Zero-fill wider destination, truncate narrower
// - Items little-endian, least byte lowest address
// - One request at a time, priority arbiter
// - Equal priority grants lowest channel number
//
// The APB register port and the register addresses were left to the implementer.
module dmace_engine (
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  input  wire logic                       clk_en,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [dmace_pkg::NCH-1:0]  periph_req,
  output logic      [dmace_pkg::NCH-1:0]  periph_ack,
  output dmace_pkg::dmace_bus_t           bus_o,
  input  wire logic [31:0]                bus_rdata,
  input  wire logic                       bus_ready,
  input  wire logic                       bus_err,
  output logic      [dmace_pkg::NCH-1:0]  irq_o
);

  // One channel's programmed and running state
  typedef struct packed {
    dmace_pkg::dmace_cfg_t cfg;      // channel_config
    logic [15:0]           init;     // Count as programmed
    logic [15:0]           cnt;      // Remaining items
    logic [31:0]           pbase;    // periph_base_addr
    logic [31:0]           mbase;    // mem_base_addr
    logic [31:0]           pcur;     // Current peripheral pointer
    logic [31:0]           mcur;     // Current memory pointer
    logic                  half;     // half_done_flag
    logic                  done;     // done_flag
    logic                  err;      // error_flag
  } dmace_chan_t;

  // Whole state of the block
  typedef struct packed {
    dmace_chan_t [dmace_pkg::NCH-1:0] ch;       // Channel bank
    dmace_pkg::dmace_fsm_t            fsm;      // Sequencer
    logic [2:0]                       sel;      // Channel in service
    dmace_pkg::dmace_bus_t            bus;      // Bus request
    logic [dmace_pkg::NCH-1:0]        ack;      // Request served pulses
    logic [dmace_pkg::NCH-1:0]        irq;      // Channel interrupts
    logic                             pready;   // APB answer
    logic                             pslverr;  // APB unmapped answer
    logic [31:0]                      prdata;   // APB read data
  } dmace_state_t;

  // Result of an APB address decode
  typedef struct packed {
    logic       hit;   // Mapped address
    logic       glob;  // Status or clear register
    logic [2:0] ch;    // Channel block
    logic [1:0] rsel;  // Register in block or global
  } dmace_dec_t;

  dmace_state_t st_ff;   // Registered state
  dmace_state_t nxt_st;  // Next state

  // Address decode, shared by read and write paths
  function automatic dmace_dec_t dec(input logic [7:0] a);
    dmace_dec_t d;
    logic [7:0] base;
    logic [7:0] off;
    d = '0;
    if (a == dmace_pkg::OFF_STATUS || a == dmace_pkg::OFF_CLEAR) begin
      d.hit  = 1'b1;
      d.glob = 1'b1;
      d.rsel = a[3:2];
    end
    for (int i = 0; i < dmace_pkg::NCH; i++) begin
      base = dmace_pkg::OFF_CH0 + 8'(i) * dmace_pkg::CH_STRIDE;
      off  = a - base;
      if (a >= base && off < dmace_pkg::CH_SPAN && a[1:0] == 2'h0) begin
        d.hit  = 1'b1;
        d.ch   = 3'(i);
        d.rsel = off[3:2];
      end
    end
    return d;
  endfunction

  // Address step of an item size: 1, 2 or 4 bytes
  function automatic logic [31:0] step(input logic [1:0] sz);
    case (sz)
      dmace_pkg::SZ_8:  return 32'h0000_0001;
      dmace_pkg::SZ_16: return 32'h0000_0002;
      default:          return 32'h0000_0004;
    endcase
  endfunction

  // Lane mask of an item size, low bits only
  function automatic logic [31:0] mask(input logic [1:0] sz);
    case (sz)
      dmace_pkg::SZ_8:  return 32'h0000_00ff;
      dmace_pkg::SZ_16: return 32'h0000_ffff;
      default:          return 32'hffff_ffff;
    endcase
  endfunction

  // Priority pick; scanning down with >= lets the lower number win ties
  function automatic logic [2:0] arb(input logic [dmace_pkg::NCH-1:0]   p,
                                     input logic [2*dmace_pkg::NCH-1:0] pl);
    logic [2:0] g;
    logic [1:0] best;
    logic       found;
    g     = 3'h0;
    best  = 2'h0;
    found = 1'b0;
    for (int i = dmace_pkg::NCH - 1; i >= 0; i--) begin
      if (p[i] && (!found || pl[2*i +: 2] >= best)) begin
        g     = 3'(i);
        best  = pl[2*i +: 2];
        found = 1'b1;
      end
    end
    return g;
  endfunction

  logic [dmace_pkg::NCH-1:0]   pend;   // Channels ready for service
  logic [2*dmace_pkg::NCH-1:0] pls;    // Priorities side by side
  logic [31:0]                 stat;   // irq_status image

  // Pending and status views, one slice per channel
  for (genvar g = 0; g < dmace_pkg::NCH; g++) begin : g_view
    assign pend[g] = st_ff.ch[g].cfg.en && st_ff.ch[g].cnt != 16'h0000 &&
                     (st_ff.ch[g].cfg.mem_to_mem_sel || periph_req[g]);
    assign pls[2*g +: 2] = st_ff.ch[g].cfg.channel_priority;
    assign stat[g*dmace_pkg::ST_W +: dmace_pkg::ST_W] = {
      st_ff.ch[g].err, st_ff.ch[g].half, st_ff.ch[g].done,
      st_ff.ch[g].err | st_ff.ch[g].half | st_ff.ch[g].done};
  end
  assign stat[31:dmace_pkg::NCH*dmace_pkg::ST_W] = '0;

  localparam logic [31:0] DATA0 = dmace_pkg::DATA_RST;  // Idle read value

  // Next-state logic: register access first, engine after, so hardware sets win
  always_comb begin
    dmace_dec_t  d;
    dmace_chan_t c;
    logic [2:0]  idx;
    logic        src_mem;
    logic [15:0] cnt_new;
    logic [31:0] item;
    d       = dec(paddr);
    c       = '0;
    idx     = 3'h0;
    src_mem = 1'b0;
    cnt_new = 16'h0000;
    item    = 32'h0000_0000;
    nxt_st  = st_ff;
    nxt_st.ack = '0;
    // Access phase takes one wait state so read data comes from a flop
    nxt_st.pready = psel & penable & ~st_ff.pready;
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pslverr = ~d.hit;
      nxt_st.prdata  = DATA0;
      if (d.hit && d.glob && d.rsel == dmace_pkg::OFF_STATUS[3:2]) begin
        nxt_st.prdata = stat;
      end else if (d.hit && !d.glob) begin
        c = st_ff.ch[d.ch];
        case (d.rsel)
          dmace_pkg::SEL_CFG: nxt_st.prdata = {{(32-dmace_pkg::CFG_W){1'b0}}, c.cfg};
          dmace_pkg::SEL_CNT:   nxt_st.prdata = {16'h0000, c.cnt};
          dmace_pkg::SEL_PADDR: nxt_st.prdata = c.pbase;
          default:              nxt_st.prdata = c.mbase;
        endcase
      end
    end
    // Write takes effect at the edge that samples pready high
    if (psel && penable && st_ff.pready && pwrite && d.hit) begin
      if (d.glob) begin
        if (d.rsel == dmace_pkg::OFF_CLEAR[3:2]) begin
          for (int i = 0; i < dmace_pkg::NCH; i++) begin
            // Clearing any-event clears all three flags
            if (pwdata[i*dmace_pkg::ST_W + dmace_pkg::ST_ANY]) begin
              nxt_st.ch[i].done = 1'b0;
              nxt_st.ch[i].half = 1'b0;
              nxt_st.ch[i].err  = 1'b0;
            end
            if (pwdata[i*dmace_pkg::ST_W + dmace_pkg::ST_DONE]) nxt_st.ch[i].done = 1'b0;
            if (pwdata[i*dmace_pkg::ST_W + dmace_pkg::ST_HALF]) nxt_st.ch[i].half = 1'b0;
            if (pwdata[i*dmace_pkg::ST_W + dmace_pkg::ST_ERR])  nxt_st.ch[i].err  = 1'b0;
          end
        end
      end else begin
        c = st_ff.ch[d.ch];
        case (d.rsel)
          dmace_pkg::SEL_CFG: begin
            nxt_st.ch[d.ch].cfg = dmace_pkg::dmace_cfg_t'(pwdata[dmace_pkg::CFG_W-1:0]);
            if (c.cfg.en) begin
              nxt_st.ch[d.ch].cfg.dir            = c.cfg.dir;
              nxt_st.ch[d.ch].cfg.circular_sel   = c.cfg.circular_sel;
              nxt_st.ch[d.ch].cfg.periph_incr_en = c.cfg.periph_incr_en;
              nxt_st.ch[d.ch].cfg.mem_incr_en    = c.cfg.mem_incr_en;
            end
            if (!c.cfg.en && pwdata[0]) begin
              nxt_st.ch[d.ch].pcur = c.pbase;
              nxt_st.ch[d.ch].mcur = c.mbase;
            end
          end
          dmace_pkg::SEL_CNT: begin
            if (!c.cfg.en) begin
              nxt_st.ch[d.ch].init = pwdata[15:0];
              nxt_st.ch[d.ch].cnt  = pwdata[15:0];
            end
          end
          dmace_pkg::SEL_PADDR: begin
            if (!c.cfg.en) begin
              nxt_st.ch[d.ch].pbase = pwdata;
              nxt_st.ch[d.ch].pcur  = pwdata;
            end
          end
          default: begin
            if (!c.cfg.en) begin
              nxt_st.ch[d.ch].mbase = pwdata;
              nxt_st.ch[d.ch].mcur  = pwdata;
            end
          end
        endcase
      end
    end
    // Engine works on the granted channel or the one in service
    // only one channel at a time
    idx     = (st_ff.fsm == dmace_pkg::FSM_IDLE) ? arb(pend, pls) : st_ff.sel;
    c       = st_ff.ch[idx];
    // memory mode still uses peripheral pointer
    src_mem = c.cfg.dir;
    cnt_new = c.cnt - 16'h0001;
    // item cut to the narrower of the two size fields
    // item sits right-aligned, byte 0 lowest
    item    = bus_rdata & mask(src_mem ? c.cfg.mem_item_size : c.cfg.periph_item_size)
              & mask(src_mem ? c.cfg.periph_item_size : c.cfg.mem_item_size);
    case (st_ff.fsm)
      dmace_pkg::FSM_IDLE: begin
        if (|pend) begin
          nxt_st.sel      = idx;
          nxt_st.fsm      = dmace_pkg::FSM_READ;
          nxt_st.bus.req  = 1'b1;
          nxt_st.bus.we   = 1'b0;
          nxt_st.bus.size = src_mem ? c.cfg.mem_item_size : c.cfg.periph_item_size;
          nxt_st.bus.addr = src_mem ? c.mcur : c.pcur;
        end
      end
      dmace_pkg::FSM_READ: begin
        if (bus_ready && bus_err) begin
          nxt_st.ch[idx].err    = 1'b1;
          nxt_st.ch[idx].cfg.en = 1'b0;
          nxt_st.bus.req        = 1'b0;
          nxt_st.fsm            = dmace_pkg::FSM_IDLE;
        end else if (bus_ready) begin
          nxt_st.fsm       = dmace_pkg::FSM_WRITE;
          nxt_st.bus.we    = 1'b1;
          nxt_st.bus.size  = src_mem ? c.cfg.periph_item_size : c.cfg.mem_item_size;
          nxt_st.bus.addr  = src_mem ? c.pcur : c.mcur;
          nxt_st.bus.wdata = item;
        end
      end
      dmace_pkg::FSM_WRITE: begin
        if (bus_ready) begin
          nxt_st.bus.req = 1'b0;
          nxt_st.bus.we  = 1'b0;
          nxt_st.fsm     = dmace_pkg::FSM_IDLE;
          if (bus_err) begin
            nxt_st.ch[idx].err    = 1'b1;
            nxt_st.ch[idx].cfg.en = 1'b0;
          end else begin
            nxt_st.ch[idx].cnt = cnt_new;
            nxt_st.ack[idx]    = ~c.cfg.mem_to_mem_sel;
            // each side steps by its own size
            if (c.cfg.periph_incr_en) begin
              nxt_st.ch[idx].pcur = c.pcur + step(c.cfg.periph_item_size);
            end
            if (c.cfg.mem_incr_en) begin
              nxt_st.ch[idx].mcur = c.mcur + step(c.cfg.mem_item_size);
            end
            if ({cnt_new, 1'b0} < {1'b0, c.init}) begin
              nxt_st.ch[idx].half = 1'b1;
            end
            if (cnt_new == 16'h0000) begin
              nxt_st.ch[idx].done = 1'b1;
              if (c.cfg.circular_sel) begin
                nxt_st.ch[idx].cnt  = c.init;
                nxt_st.ch[idx].pcur = c.pbase;
                nxt_st.ch[idx].mcur = c.mbase;
              end
            end
          end
        end
      end
      default: begin
        nxt_st.fsm     = dmace_pkg::FSM_IDLE;
        nxt_st.bus.req = 1'b0;
      end
    endcase
    for (int i = 0; i < dmace_pkg::NCH; i++) begin
      nxt_st.irq[i] = (st_ff.ch[i].half & st_ff.ch[i].cfg.half_done_irq_en) |
                      (st_ff.ch[i].done & st_ff.ch[i].cfg.done_irq_en) |
                      (st_ff.ch[i].err  & st_ff.ch[i].cfg.error_irq_en);
    end
  end

  // State register; clock enable freezes everything except the synchronous reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign prdata     = st_ff.prdata;
  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign periph_ack = st_ff.ack;
  assign bus_o      = st_ff.bus;
  assign irq_o      = st_ff.irq;

  // Views of the channel in service for the checks below
  dmace_chan_t cur;
  logic        run;
  assign cur = st_ff.ch[st_ff.sel];
  assign run = clk_en && bus_ready;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_read_ok;
    run && st_ff.fsm == dmace_pkg::FSM_READ && !bus_err;
  endsequence
  sequence s_write_ok;
    run && st_ff.fsm == dmace_pkg::FSM_WRITE && !bus_err;
  endsequence

  property p_read_then_write;
    s_read_ok |=> st_ff.fsm == dmace_pkg::FSM_WRITE && st_ff.bus.req && st_ff.bus.we;
  endproperty
  a_read_then_write: assert property (p_read_then_write) else $error("no write after read");

  property p_count_dec;
    s_write_ok ##0 (cur.cnt != 16'h0001 || !cur.cfg.circular_sel) |=>
      cur.cnt == $past(cur.cnt) - 16'h0001;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");

  property p_done;
    s_write_ok ##0 cur.cnt == 16'h0001 |=> cur.done ##1 (st_ff.fsm != dmace_pkg::FSM_WRITE);
  endproperty
  a_done: assert property (p_done) else $error("done flag missing at zero");

  property p_circular_sel_reload;
    s_write_ok ##0 (cur.cnt == 16'h0001 && cur.cfg.circular_sel) |=>
      cur.cnt == cur.init && cur.pcur == cur.pbase && cur.mcur == cur.mbase;
  endproperty
  a_circular_sel_reload: assert property (p_circular_sel_reload) else $error("circular reload missing");

  property p_error_stop;
    (run && bus_err && st_ff.fsm != dmace_pkg::FSM_IDLE) |=>
      cur.err && !cur.cfg.en && !st_ff.bus.req;
  endproperty
  a_error_stop: assert property (p_error_stop) else $error("error did not stop channel");

  property p_start;
    (clk_en && st_ff.fsm == dmace_pkg::FSM_IDLE && |pend) |=>
      st_ff.fsm == dmace_pkg::FSM_READ && st_ff.bus.req && !st_ff.bus.we;
  endproperty
  a_start: assert property (p_start) else $error("pending channel not started");

  property p_addr_lock;
    (clk_en && psel && penable && st_ff.pready && pwrite && st_ff.ch[2].cfg.en &&
     paddr == 8'(dmace_pkg::OFF_CH0 + 2 * dmace_pkg::CH_STRIDE + 8'h08)) |=>
      $stable(st_ff.ch[2].pbase);
  endproperty
  a_addr_lock: assert property (p_addr_lock) else $error("base written while enabled");

  property p_periph_step;
    s_write_ok ##0 (cur.cfg.periph_incr_en && !cur.cfg.circular_sel) |=>
      cur.pcur == $past(cur.pcur) + step($past(cur.cfg.periph_item_size));
  endproperty
  a_periph_step: assert property (p_periph_step) else $error("pointer step wrong");

  property p_trim;
    (st_ff.fsm == dmace_pkg::FSM_WRITE && st_ff.bus.size == dmace_pkg::SZ_8) |->
      st_ff.bus.wdata[31:8] == 24'h00_0000;
  endproperty
  a_trim: assert property (p_trim) else $error("narrow item not trimmed");

  property p_irq_done;
    (clk_en && st_ff.ch[0].done && st_ff.ch[0].cfg.done_irq_en) |=> irq_o[0];
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("done interrupt missing");

endmodule

// file: tb/dmace_mem.sv
// System bus memory model facing the DMA engine
module dmace_mem (
  input  wire logic                  core_clk,
  input  wire dmace_pkg::dmace_bus_t bus_i,
  input  wire logic                  slow,
  output logic [31:0]                bus_rdata,
  output logic                       bus_ready,
  output logic                       bus_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];     // Sparse byte store, little-endian
  logic       wt_ff = 1'b0;  // Wait state already spent
  initial begin
    bus_rdata = 32'h0;
    bus_ready = 1'b0;
    bus_err   = 1'b0;
  end
  // One answer per request; slow adds one wait state
  always @(posedge core_clk) begin
    bus_rdata <= ~bus_rdata;  // Idle data toggles, never stale
    bus_ready <= 1'b0;
    bus_err   <= 1'b0;
    if (bus_ready) begin
      wt_ff <= 1'b0;
      // Writes land only at the completing edge
      if (bus_i.we && !bus_err)
        for (int j = 0; j < (1 << bus_i.size); j++) mem[bus_i.addr + j] = bus_i.wdata[8*j +: 8];
    end else if (bus_i.req && (wt_ff || !slow)) begin
      bus_ready <= 1'b1;
      bus_err   <= (bus_i.addr[31:28] == 4'hf);  // Top region reserved
      for (int j = 0; j < 4; j++)
        bus_rdata[8*j +: 8] <= mem.exists(bus_i.addr + j) ? mem[bus_i.addr + j] : 8'h00;
    end else if (bus_i.req) begin
      wt_ff <= 1'b1;
    end
  end
endmodule

// file: tb/dma_channel_transfer_engine_tb.sv
// Self-checking bench of the DMA transfer engine
module dma_channel_transfer_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk = 1'b0;
  logic                  resetn   = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [7:0]            paddr  = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, bus_rdata;
  logic                  pready, pslverr, bus_ready, bus_err;
  logic [6:0]            periph_req = 7'h00, periph_ack, irq_o;
  dmace_pkg::dmace_bus_t bus_o;
  logic [32:0]           exp_q[$];  // Expected {pslverr, prdata} per read
  logic [7:0]            src[16];   // Source bytes of a round
  int miscompares = 0, n_tests = 0, cycles = 0, acks = 0;

  dmace_engine i_dmace_engine (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
    .periph_ack(periph_ack), .bus_o(bus_o), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .bus_err(bus_err), .irq_o(irq_o));
  dmace_mem i_dmace_mem (.core_clk(core_clk), .bus_i(bus_o), .slow(slow),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_err(bus_err));

  always #50 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Watchdog and ack counter; a hang ends the run
  always @(posedge core_clk) begin
    cycles++;
    if (periph_ack[1] === 1'b1) acks++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  // Read results taken at the ready edge
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());

  // APB cycle, held until pready, one idle cycle after
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [7:0] cb(input int ch, input logic [7:0] o);
    return 8'(dmace_pkg::OFF_CH0 + dmace_pkg::CH_STRIDE * ch + o);
  endfunction

  task automatic wait_irq(input int ch);
    repeat (2000) if (irq_o[ch] !== 1'b1) @(posedge core_clk);
    check(irq_o[ch], 1'b1);
  endtask

  // Two requests raised together; the first item served shows the winner
  task automatic race(input logic [31:0] cfg3, input logic [31:0] cfg4, input logic [1:0] exp);
    apb(1, cb(3, 8'h4), 32'h1, 0);
    apb(1, cb(4, 8'h4), 32'h1, 0);
    apb(1, cb(3, 8'h0), cfg3, 0);
    apb(1, cb(4, 8'h0), cfg4, 0);
    periph_req <= 7'h18;
    repeat (50) if (periph_ack[4:3] == 2'b00) @(posedge core_clk);
    check(periph_ack[4:3], exp);
    periph_req <= 7'h00;
    repeat (20) @(posedge core_clk);
    apb(1, cb(3, 8'h0), 32'h0, 0);
    apb(1, cb(4, 8'h0), 32'h0, 0);
    apb(1, dmace_pkg::OFF_CLEAR, 32'h0001_1000, 0);
  endtask

  initial begin
    int s;
    s = $urandom(32'hbead7dd2);
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // Reset values, unmapped hole refused
    apb(0, dmace_pkg::OFF_STATUS, 0, 33'h0);
    apb(0, cb(0, 8'h4), 0, 33'h0);
    apb(0, cb(0, 8'h10), 0, 33'h1_0000_0000);
    $display("test reset done");
    // Every size pair, memory to memory
    for (int ps = 0; ps < 3; ps++) for (int ms = 0; ms < 3; ms++) begin
      i_dmace_mem.mem.delete();
      for (int k = 0; k < 16; k++) begin
        src[k] = 8'($urandom);
        i_dmace_mem.mem[32'h100 + k] = src[k];
      end
      slow <= 1'($urandom);
      apb(1, cb(0, 8'h8), 32'h100, 0);
      apb(1, cb(0, 8'hc), 32'h200, 0);
      apb(1, cb(0, 8'h4), 32'h4, 0);
      // circular left clear in memory mode
      apb(1, cb(0, 8'h0), 32'h40c3 | (ps << 8) | (ms << 10), 0);
      wait_irq(0);
      apb(0, dmace_pkg::OFF_STATUS, 0, 33'h7);
      apb(0, cb(0, 8'h4), 0, 33'h0);
      // Width, zero fill, truncation, byte order
      for (int i = 0; i < 4; i++) for (int j = 0; j < (1 << ms); j++)
        check(i_dmace_mem.mem[32'h200 + i * (1 << ms) + j],
              j < (1 << ps) ? src[i * (1 << ps) + j] : 8'h00);
      apb(1, dmace_pkg::OFF_CLEAR, 32'h1, 0);
      apb(1, cb(0, 8'h0), 32'h0, 0);
      check(irq_o[0], 1'b0);
    end
    $display("test sizes done");
    // Locked fields while enabled, no request given
    apb(1, cb(2, 8'h8), 32'h400, 0);
    apb(1, cb(2, 8'h4), 32'h3, 0);
    apb(1, cb(2, 8'h0), 32'h1, 0);
    apb(1, cb(2, 8'h4), 32'h9, 0);
    apb(1, cb(2, 8'h8), 32'h500, 0);
    apb(0, cb(2, 8'h4), 0, 33'h3);
    apb(0, cb(2, 8'h8), 0, 33'h400);
    apb(1, cb(2, 8'h0), 32'h0, 0);
    apb(1, cb(2, 8'h4), 32'h9, 0);
    apb(0, cb(2, 8'h4), 0, 33'h9);
    $display("test lock done");
    // Circular peripheral to memory, fixed source
    i_dmace_mem.mem.delete();
    i_dmace_mem.mem[32'h180] = src[0];
    apb(1, cb(1, 8'h8), 32'h180, 0);
    apb(1, cb(1, 8'hc), 32'h300, 0);
    apb(1, cb(1, 8'h4), 32'h2, 0);
    apb(1, cb(1, 8'h0), 32'ha1, 0);
    periph_req[1] <= 1'b1;
    repeat (400) if (acks < 4) @(posedge core_clk);
    periph_req[1] <= 1'b0;
    repeat (20) @(posedge core_clk);
    check(i_dmace_mem.mem[32'h301], src[0]);
    check(i_dmace_mem.mem.exists(32'h302), 1'b0);
    apb(0, cb(1, 8'h0), 0, 33'ha1);
    apb(0, dmace_pkg::OFF_STATUS, 0, 33'h70);
    apb(1, dmace_pkg::OFF_CLEAR, 32'h10, 0);
    apb(1, cb(1, 8'h0), 32'h0, 0);
    $display("test circular done");
    // Equal priority, then the higher priority on the higher number
    race(32'h11, 32'h1, 2'b01);
    race(32'h1, 32'h3001, 2'b10);
    $display("test arbiter done");
    // Reserved source, memory side read first
    apb(1, cb(0, 8'hc), 32'hf000_0000, 0);
    apb(1, cb(0, 8'h4), 32'h2, 0);
    apb(1, cb(0, 8'h0), 32'h4019, 0);
    wait_irq(0);
    apb(0, dmace_pkg::OFF_STATUS, 0, 33'h9);
    apb(0, cb(0, 8'h0), 0, 33'h4018);
    $display("test error done");
    stop_test();
  end
endmodule
